// [core/smoc_pkg.sv]
package smoc_pkg;
    localparam int CODE_W = 14;
    localparam int WORD_W = 16;
    // Main output configuration word
    localparam int OSEL_LSB = 1;
    localparam logic [1:0] OSEL_PDM = 2'h2;
    localparam int MODE_BIT = 7;
    localparam int CAL_LSB = 3;
    // Alarm configuration word
    localparam int HI_POL_BIT = 0;
    localparam int HI_OD_BIT = 1;
    localparam int LO_POL_BIT = 2;
    localparam int LO_OD_BIT = 3;
    // Front-end configuration words: resolution field
    localparam int RES_LSB = 10;
    localparam logic [1:0] RES_8 = 2'h0;
    localparam logic [1:0] RES_10 = 2'h1;
    localparam logic [1:0] RES_12 = 2'h2;
    localparam logic [1:0] RES_14 = 2'h3;
    // Reset values
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [13:0] CODE_RST = 14'h0000;
    // Density bit period
    localparam int CLK_PERIOD_NS = 5;
    localparam int PDM_BIT_NS = 20;
    localparam int PDM_DIV = (PDM_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] PDM_DIV_LAST = 4'(PDM_DIV - 1);
endpackage

// [core/smoc_pdm.sv]
`timescale 1ns/1ps
`default_nettype none
module smoc_pdm (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bit-rate enable and code
    input wire logic bit_en,
    input wire logic [13:0] code,
    // Density stream
    output logic pdm_o
);
    logic [14:0] sum;
    logic [13:0] acc_r;
    logic [13:0] acc_nxt;
    logic pdm_nxt;

    // First-order modulator: carry out is the density bit
    always_comb
    begin
        sum = {1'b0, acc_r} + {1'b0, code};
        acc_nxt = acc_r;
        pdm_nxt = pdm_o;
        if (bit_en)
        begin
            acc_nxt = sum[13:0];
            pdm_nxt = sum[14];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            acc_r <= smoc_pkg::CODE_RST;
            pdm_o <= 1'b0;
        end
        else
        begin
            acc_r <= acc_nxt;
            pdm_o <= pdm_nxt;
        end
    end
endmodule
`default_nettype wire

// [core/smoc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module smoc_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Power-up configuration load
    input wire logic cfg_load,
    input wire logic [15:0] main_output_config_word,
    input wire logic [15:0] alarm_config_word,
    input wire logic [15:0] cap_front_end_word,
    input wire logic [15:0] temp_front_end_word,
    input wire logic [15:0] density_output_upper_limit,
    input wire logic [15:0] density_output_lower_limit,
    input wire logic [15:0] alarm_high_trip,
    input wire logic [15:0] alarm_high_hyst,
    input wire logic [15:0] alarm_low_trip,
    input wire logic [15:0] alarm_low_hyst,
    // Corrected readings
    input wire logic reading_valid,
    input wire logic [13:0] cap_reading,
    input wire logic [13:0] temp_reading,
    // Status
    output logic cfg_loaded,
    output logic update_mode,
    output logic density_mode,
    output logic cfg_conflict,
    output logic [1:0] cap_res,
    output logic [1:0] temp_res,
    output logic [13:0] cap_result,
    output logic [13:0] temp_result,
    output logic result_valid,
    // Pins
    output logic pdm_cap_o,
    output logic alarm_high_o,
    output logic alarm_high_oe_n,
    output logic alarm_low_o,
    output logic alarm_low_oe_n
);
    logic loaded_r, loaded_nxt;
    logic [15:0] main_r, main_nxt, alm_cfg_r, alm_cfg_nxt;
    logic [15:0] upper_r, upper_nxt, lower_r, lower_nxt;
    logic [15:0] hi_trip_r, hi_trip_nxt, hi_hyst_r, hi_hyst_nxt;
    logic [15:0] lo_trip_r, lo_trip_nxt, lo_hyst_r, lo_hyst_nxt;
    logic [1:0] cres_r, cres_nxt, tres_r, tres_nxt;
    logic [13:0] cq_r, cq_nxt, tq_r, tq_nxt;
    logic [13:0] ccode_r, ccode_nxt, tcode_r, tcode_nxt;
    logic alm_hi_r, alm_hi_nxt, alm_lo_r, alm_lo_nxt;
    logic rv_r, rv_nxt;
    logic [3:0] div_r, div_nxt;
    logic bit_en;
    logic pdm_cap, pdm_temp;
    logic hi_o_nxt, hi_oe_n_nxt, lo_o_nxt, lo_oe_n_nxt;
    logic hi_o_r, hi_oe_n_r, lo_o_r, lo_oe_n_r;
    logic is_pdm;
    logic [13:0] cq_new, tq_new;
    logic hi_lvl, lo_lvl;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Keeps the top bits of a 14-bit reading for the selected resolution
    function automatic logic [13:0] res_mask(input logic [1:0] r);
        case (r)
            smoc_pkg::RES_8: res_mask = 14'h3fc0;
            smoc_pkg::RES_10: res_mask = 14'h3ff0;
            smoc_pkg::RES_12: res_mask = 14'h3ffc;
            default: res_mask = 14'h3fff;
        endcase
    endfunction

    // Clamps a code between the two limit words
    function automatic logic [13:0] clip(input logic [13:0] v,
        input logic [15:0] lo, input logic [15:0] hi);
        if ({2'h0, v} > hi)
            clip = hi[13:0];
        else if ({2'h0, v} < lo)
            clip = lo[13:0];
        else
            clip = v;
    endfunction

    assign is_pdm = main_r[smoc_pkg::OSEL_LSB +: 2] == smoc_pkg::OSEL_PDM;

    always_comb
    begin
        loaded_nxt = loaded_r;
        main_nxt = main_r;
        alm_cfg_nxt = alm_cfg_r;
        upper_nxt = upper_r;
        lower_nxt = lower_r;
        hi_trip_nxt = hi_trip_r;
        hi_hyst_nxt = hi_hyst_r;
        lo_trip_nxt = lo_trip_r;
        lo_hyst_nxt = lo_hyst_r;
        cres_nxt = cres_r;
        tres_nxt = tres_r;
        cq_nxt = cq_r;
        tq_nxt = tq_r;
        ccode_nxt = ccode_r;
        tcode_nxt = tcode_r;
        alm_hi_nxt = alm_hi_r;
        alm_lo_nxt = alm_lo_r;
        rv_nxt = 1'b0;
        cq_new = cap_reading & res_mask(cres_r);
        tq_new = temp_reading & res_mask(tres_r);
        // Configuration is taken only from the load strobe
        if (cfg_load)
        begin
            loaded_nxt = 1'b1;
            main_nxt = main_output_config_word;
            alm_cfg_nxt = alarm_config_word;
            upper_nxt = density_output_upper_limit;
            lower_nxt = density_output_lower_limit;
            hi_trip_nxt = alarm_high_trip;
            hi_hyst_nxt = alarm_high_hyst;
            lo_trip_nxt = alarm_low_trip;
            lo_hyst_nxt = alarm_low_hyst;
            cres_nxt = cap_front_end_word[smoc_pkg::RES_LSB +: 2];
            tres_nxt = temp_front_end_word[smoc_pkg::RES_LSB +: 2];
        end
        else if (loaded_r && reading_valid)
        begin
            rv_nxt = 1'b1;
            cq_nxt = cq_new;
            tq_nxt = tq_new;
            ccode_nxt = clip(cq_new, lower_r, upper_r);
            tcode_nxt = clip(tq_new, lower_r, upper_r);
            // Trip and release with hysteresis
            if ({2'h0, cq_new} > hi_trip_r)
                alm_hi_nxt = 1'b1;
            else if ({3'h0, cq_new} + {1'b0, hi_hyst_r} < {1'b0, hi_trip_r})
                alm_hi_nxt = 1'b0;
            if ({2'h0, cq_new} < lo_trip_r)
                alm_lo_nxt = 1'b1;
            else if ({3'h0, cq_new} > {1'b0, lo_trip_r} + {1'b0, lo_hyst_r})
                alm_lo_nxt = 1'b0;
        end
        div_nxt = (div_r == smoc_pkg::PDM_DIV_LAST) ? 4'h0 : div_r + 4'h1;
        // Pin levels: polarity flips the active level
        hi_lvl = alm_hi_r ^ alm_cfg_r[smoc_pkg::HI_POL_BIT];
        lo_lvl = alm_lo_r ^ alm_cfg_r[smoc_pkg::LO_POL_BIT];
        hi_o_nxt = 1'b0;
        hi_oe_n_nxt = 1'b1;
        lo_o_nxt = 1'b0;
        lo_oe_n_nxt = 1'b1;
        if (loaded_r)
        begin
            hi_o_nxt = alm_cfg_r[smoc_pkg::HI_OD_BIT] ? 1'b0 : hi_lvl;
            hi_oe_n_nxt = alm_cfg_r[smoc_pkg::HI_OD_BIT] ? hi_lvl : 1'b0;
            if (is_pdm)
            begin
                lo_o_nxt = pdm_temp;
                lo_oe_n_nxt = 1'b0;
            end
            else
            begin
                lo_o_nxt = alm_cfg_r[smoc_pkg::LO_OD_BIT] ? 1'b0 : lo_lvl;
                lo_oe_n_nxt = alm_cfg_r[smoc_pkg::LO_OD_BIT] ? lo_lvl : 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            loaded_r <= 1'b0;
            main_r <= smoc_pkg::WORD_RST;
            alm_cfg_r <= smoc_pkg::WORD_RST;
            upper_r <= smoc_pkg::WORD_RST;
            lower_r <= smoc_pkg::WORD_RST;
            hi_trip_r <= smoc_pkg::WORD_RST;
            hi_hyst_r <= smoc_pkg::WORD_RST;
            lo_trip_r <= smoc_pkg::WORD_RST;
            lo_hyst_r <= smoc_pkg::WORD_RST;
            cres_r <= smoc_pkg::RES_14;
            tres_r <= smoc_pkg::RES_14;
            cq_r <= smoc_pkg::CODE_RST;
            tq_r <= smoc_pkg::CODE_RST;
            ccode_r <= smoc_pkg::CODE_RST;
            tcode_r <= smoc_pkg::CODE_RST;
            alm_hi_r <= 1'b0;
            alm_lo_r <= 1'b0;
            rv_r <= 1'b0;
            div_r <= 4'h0;
            hi_o_r <= 1'b0;
            hi_oe_n_r <= 1'b1;
            lo_o_r <= 1'b0;
            lo_oe_n_r <= 1'b1;
        end
        else
        begin
            loaded_r <= loaded_nxt;
            main_r <= main_nxt;
            alm_cfg_r <= alm_cfg_nxt;
            upper_r <= upper_nxt;
            lower_r <= lower_nxt;
            hi_trip_r <= hi_trip_nxt;
            hi_hyst_r <= hi_hyst_nxt;
            lo_trip_r <= lo_trip_nxt;
            lo_hyst_r <= lo_hyst_nxt;
            cres_r <= cres_nxt;
            tres_r <= tres_nxt;
            cq_r <= cq_nxt;
            tq_r <= tq_nxt;
            ccode_r <= ccode_nxt;
            tcode_r <= tcode_nxt;
            alm_hi_r <= alm_hi_nxt;
            alm_lo_r <= alm_lo_nxt;
            rv_r <= rv_nxt;
            div_r <= div_nxt;
            hi_o_r <= hi_o_nxt;
            hi_oe_n_r <= hi_oe_n_nxt;
            lo_o_r <= lo_o_nxt;
            lo_oe_n_r <= lo_oe_n_nxt;
        end
    end

    // Modulators run only once loaded and in density mode
    assign bit_en = (div_r == smoc_pkg::PDM_DIV_LAST) && loaded_r && is_pdm;

    smoc_pdm u_pdm_cap (
        .clk(clk),
        .rst_b(rst_b),
        .bit_en(bit_en),
        .code(ccode_r),
        .pdm_o(pdm_cap)
    );

    smoc_pdm u_pdm_temp (
        .clk(clk),
        .rst_b(rst_b),
        .bit_en(bit_en),
        .code(tcode_r),
        .pdm_o(pdm_temp)
    );

    assign pdm_cap_o = pdm_cap & is_pdm & loaded_r;
    assign alarm_high_o = hi_o_r;
    assign alarm_high_oe_n = hi_oe_n_r;
    assign alarm_low_o = lo_o_r;
    assign alarm_low_oe_n = lo_oe_n_r;
    assign cfg_loaded = loaded_r;
    assign update_mode = main_r[smoc_pkg::MODE_BIT];
    assign density_mode = is_pdm & loaded_r;
    // Flags a density selection left in sleep mode
    assign cfg_conflict = loaded_r & is_pdm & ~main_r[smoc_pkg::MODE_BIT];
    assign cap_res = cres_r;
    assign temp_res = tres_r;
    assign cap_result = cq_r;
    assign temp_result = tq_r;
    assign result_valid = rv_r;

    sequence load_s;
        cfg_load ##1 loaded_r;
    endsequence

    sequence pins_idle_s;
        alarm_high_oe_n && alarm_low_oe_n && !pdm_cap_o;
    endsequence

    load_done_a: assert property (
        cfg_load |-> load_s)
        else $error("load did not mark configuration loaded");
    idle_unloaded_a: assert property (
        !loaded_r && !$past(loaded_r) |-> pins_idle_s)
        else $error("pins active before configuration load");
    pdm_route_a: assert property (
        !density_mode |-> !pdm_cap_o)
        else $error("density stream outside density mode");
    clip_range_a: assert property (
        result_valid && lower_r <= upper_r && upper_r < 16'h4000
        |-> {2'h0, ccode_r} >= lower_r && {2'h0, ccode_r} <= upper_r)
        else $error("density code outside clipping limits");
    high_trip_a: assert property (
        loaded_r && !cfg_load && reading_valid && {2'h0, cq_new} > hi_trip_r
        |=> alm_hi_r ##1 (alm_cfg_r[smoc_pkg::HI_OD_BIT]
        || alarm_high_o != alm_cfg_r[smoc_pkg::HI_POL_BIT]))
        else $error("high alarm not raised above trip point");
    low_trip_a: assert property (
        loaded_r && !cfg_load && reading_valid && {2'h0, cq_new} < lo_trip_r
        |=> alm_lo_r)
        else $error("low alarm not raised below trip point");
    pin_drive_a: assert property (
        loaded_r && !alm_cfg_r[smoc_pkg::HI_OD_BIT] && $stable(alm_cfg_r)
        |=> !alarm_high_oe_n && alarm_high_o == $past(hi_lvl))
        else $error("push-pull high alarm pin level wrong");
    temp_stream_a: assert property (
        density_mode && $stable(density_mode)
        |=> !alarm_low_oe_n && alarm_low_o == $past(pdm_temp))
        else $error("temperature stream missing on low alarm pin");
    res_quant_a: assert property (
        result_valid && cres_r == smoc_pkg::RES_10 |-> cq_r[3:0] == 4'h0)
        else $error("capacitance result finer than selected resolution");
endmodule
`default_nettype wire

// [dv/smoc_load_model.sv]
`timescale 1ns/1ps
`default_nettype none
module smoc_load_model (
    // Clock and filter window
    input wire logic clk,
    input wire logic win_clr,
    input wire logic win_en,
    // Device pins
    input wire logic pdm_cap_o,
    input wire logic alarm_high_o,
    input wire logic alarm_high_oe_n,
    input wire logic alarm_low_o,
    input wire logic alarm_low_oe_n,
    // Resolved lines and filter sums
    output logic alarm_high_pin,
    output logic alarm_low_pin,
    output logic [15:0] cap_sum,
    output logic [15:0] temp_sum
);
    // Pull-ups hold released alarm lines high
    assign alarm_high_pin = alarm_high_oe_n ? 1'b1 : alarm_high_o;
    assign alarm_low_pin = alarm_low_oe_n ? 1'b1 : alarm_low_o;
    // Counting high cycles stands in for the low-pass filters
    always @(posedge clk)
    begin
        if (win_clr)
        begin
            cap_sum <= 16'h0000;
            temp_sum <= 16'h0000;
        end
        else if (win_en)
        begin
            cap_sum <= cap_sum + 16'(pdm_cap_o);
            temp_sum <= temp_sum + 16'(alarm_low_pin);
        end
    end
endmodule
`default_nettype wire

// [dv/tb_smoc_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_smoc_top;
    localparam logic [13:0] CAPS [8] = '{14'h2000, 14'h3000, 14'h3001,
        14'h2f80, 14'h2eff, 14'h0fff, 14'h1080, 14'h1101};
    logic clk, rst_b, cfg_load, reading_valid, win_clr, win_en;
    logic [15:0] main_w, alarm_w, cap_fe, temp_fe, up_lim, lo_lim;
    logic [13:0] cap_rd, temp_rd, cap_result, temp_result;
    logic cfg_loaded, update_mode, density_mode, cfg_conflict, result_valid;
    logic [1:0] cap_res, temp_res;
    logic pdm_cap_o, ah_o, ah_oe_n, al_o, al_oe_n, ah_pin, al_pin;
    logic [15:0] cap_sum, temp_sum;
    int mismatches, n_tests;
    smoc_top dut (.clk(clk), .rst_b(rst_b), .cfg_load(cfg_load),
        .main_output_config_word(main_w), .alarm_config_word(alarm_w),
        .cap_front_end_word(cap_fe), .temp_front_end_word(temp_fe),
        .density_output_upper_limit(up_lim),
        .density_output_lower_limit(lo_lim),
        .alarm_high_trip(16'h3000), .alarm_high_hyst(16'h0100),
        .alarm_low_trip(16'h1000), .alarm_low_hyst(16'h0100),
        .reading_valid(reading_valid), .cap_reading(cap_rd),
        .temp_reading(temp_rd), .cfg_loaded(cfg_loaded),
        .update_mode(update_mode), .density_mode(density_mode),
        .cfg_conflict(cfg_conflict), .cap_res(cap_res), .temp_res(temp_res),
        .cap_result(cap_result), .temp_result(temp_result),
        .result_valid(result_valid), .pdm_cap_o(pdm_cap_o),
        .alarm_high_o(ah_o), .alarm_high_oe_n(ah_oe_n),
        .alarm_low_o(al_o), .alarm_low_oe_n(al_oe_n));
    smoc_load_model loads (.clk(clk), .win_clr(win_clr), .win_en(win_en),
        .pdm_cap_o(pdm_cap_o), .alarm_high_o(ah_o),
        .alarm_high_oe_n(ah_oe_n), .alarm_low_o(al_o),
        .alarm_low_oe_n(al_oe_n), .alarm_high_pin(ah_pin),
        .alarm_low_pin(al_pin), .cap_sum(cap_sum), .temp_sum(temp_sum));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic near(input logic [15:0] got, input logic [15:0] exp,
        input logic [15:0] tol);
        n_tests++;
        if ($isunknown(got) || got > exp + tol || got + tol < exp)
        begin
            mismatches++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic load(input logic [15:0] m, a, cf, tf);
        @(posedge clk);
        main_w <= m;
        alarm_w <= a;
        cap_fe <= cf;
        temp_fe <= tf;
        cfg_load <= 1'b1;
        @(posedge clk);
        cfg_load <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [13:0] c, input logic [13:0] t);
        @(posedge clk);
        cap_rd <= c;
        temp_rd <= t;
        reading_valid <= 1'b1;
        @(posedge clk);
        reading_valid <= 1'b0;
        #1;
    endtask
    task automatic win();
        @(posedge clk);
        win_clr <= 1'b1;
        @(posedge clk);
        win_clr <= 1'b0;
        win_en <= 1'b1;
        repeat (1024) @(posedge clk);
        win_en <= 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic t_reset();
        #1;
        chk(cfg_loaded, 0);
        chk(cap_res, 3);
        chk({ah_oe_n, al_oe_n, pdm_cap_o}, 6);
        rd(14'h3fff, 14'h0000);
        chk(result_valid, 0);
        $display("reset test done");
    endtask
    task automatic t_res();
        for (int k = 0; k < 4; k++)
        begin
            load(16'h0088, 16'h0000, 16'(k) << 10, 16'(3 - k) << 10);
            chk({cap_res, temp_res}, 16'((k << 2) | (3 - k)));
            rd(14'h3fff, 14'h3fff);
            chk(cap_result, 14'(14'h3fff << (6 - 2 * k)));
            chk(temp_result, 14'(14'h3fff << (2 * k)));
        end
        $display("resolution test done");
    endtask
    task automatic t_alarm();
        // Update mode and calibration bits set, serial output path
        load(16'h0088, 16'h0000, 16'h0c00, 16'h0c00);
        chk({cfg_loaded, update_mode, density_mode}, 6);
        for (int i = 0; i < 8; i++)
        begin
            rd(CAPS[i], 14'h0123);
            chk({result_valid, 1'b0, cap_result}, {2'h2, CAPS[i]});
            @(posedge clk);
            #1;
            chk(result_valid, 0);
            chk({ah_oe_n, al_oe_n}, 0);
            chk({ah_pin, al_pin}, {1'(8'h0c >> i), 1'(8'h60 >> i)});
        end
        win();
        chk(cap_sum, 0);
        $display("alarm test done");
    endtask
    task automatic t_pol();
        load(16'h0088, 16'h0007, 16'h0c00, 16'h0c00);
        rd(14'h2000, 14'h0000);
        @(posedge clk);
        #1;
        chk({ah_oe_n, ah_pin, al_oe_n, al_o}, 16'hd);
        rd(14'h3001, 14'h0000);
        @(posedge clk);
        #1;
        chk({ah_oe_n, ah_o, ah_pin}, 0);
        $display("polarity test done");
    endtask
    task automatic t_density();
        @(posedge clk);
        up_lim <= 16'h3999;
        lo_lim <= 16'h0666;
        load(16'h008c, 16'h0000, 16'h0c00, 16'h0c00);
        chk({density_mode, cfg_conflict}, 2);
        rd(14'h3fff, 14'h0000);
        @(posedge clk);
        #1;
        chk(al_oe_n, 0);
        win();
        near(cap_sum, 922, 8);
        near(temp_sum, 102, 8);
        rd(14'h0000, 14'h3fff);
        win();
        near(cap_sum, 102, 8);
        near(temp_sum, 922, 8);
        load(16'h000c, 16'h0000, 16'h0c00, 16'h0c00);
        chk({update_mode, cfg_conflict}, 1);
        $display("density test done");
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
    initial
    begin
        mismatches = 0;
        n_tests = 0;
        {rst_b, cfg_load, reading_valid, win_clr, win_en} = 5'h00;
        {main_w, alarm_w, cap_fe, temp_fe, up_lim, lo_lim} = 96'h0;
        {cap_rd, temp_rd} = 28'h0;
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_res();
        t_alarm();
        t_pol();
        t_density();
        end_of_test();
    end
endmodule
`default_nettype wire
